// ===== dv/tb_sleep_wake_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_sleep_wake_control
  import sleep_wake_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sleep_instr = 1'b0;
  logic wd_clr = 1'b0;
  logic [7:0] wake_flags;
  logic [7:0] raise = 8'h00;
  logic clear_all = 1'b0;
  logic pin_low = 1'b0;
  io_drive_type io_core = '0;
  io_drive_type io_pins;
  logic mc_n, mc_out, mc_oe, osc_en, asleep, core_reset, prefetch, resume, vb;
  logic [12:0] vector_addr;
  logic to_n, pd_n;
  int miscompares = 0;
  int cmp_count = 0;
  int n;
  logic vb_seen;
  logic [7:0] en, fl;
  logic [7:0] rd;
  io_drive_type held;

  always #12.5 ref_clk = ~ref_clk;

  wake_source_model partner (.ref_clk(ref_clk), .nrst(nrst), .raise(raise),
    .clear_all(clear_all), .pin_low(pin_low), .pin_oe(mc_oe), .pin_out(mc_out),
    .wake_flags(wake_flags), .master_clear_pin_n(mc_n));

  sleep_wake_control dut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_instr(sleep_instr), .watchdog_clear_instr(wd_clr), .wake_flags(wake_flags),
    .io_core(io_core), .io_pins(io_pins), .master_clear_pin_n(mc_n),
    .master_clear_pin_out(mc_out), .master_clear_pin_oe(mc_oe), .osc_driver_en(osc_en),
    .asleep(asleep), .core_reset(core_reset), .prefetch_next(prefetch),
    .core_resume(resume), .vector_branch(vb), .vector_addr(vector_addr),
    .timeout_flag_n(to_n), .powerdown_flag_n(pd_n));

  // ==========================================================================
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rdr

  task automatic sleep_now();
    @(posedge ref_clk);
    sleep_instr <= 1'b1;
    @(posedge ref_clk);
    sleep_instr <= 1'b0;
    #1 check(prefetch, 1'b1);
  endtask : sleep_now

  task automatic pulse_clear();
    @(posedge ref_clk);
    clear_all <= 1'b1;
    wd_clr <= 1'b1;
    @(posedge ref_clk);
    clear_all <= 1'b0;
    wd_clr <= 1'b0;
  endtask : pulse_clear

  // Counts cycles until the wake completes; vb_seen holds the branch request
  task automatic wait_resume();
    n = 0;
    vb_seen = 1'b0;
    while (n < 2000) begin
      @(posedge ref_clk);
      #1 n++;
      if (resume === 1'b1) begin
        vb_seen = vb;
        break;
      end
    end
  endtask : wait_resume

  function automatic logic [7:0] pick(input logic [7:0] m);
    return m & (~m + 8'h01);
  endfunction : pick

  // ==========================================================================
  // Tests
  initial begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    conclude();
  end

  initial begin
    void'($urandom(32'hc9ab));
    cyc(20);
    nrst <= 1'b1;
    #1 check({osc_en, to_n, pd_n, asleep, mc_oe}, 5'h1c);
    rdr(ADDR_CTRL, rd); check(rd, 8'h00);
    rdr(ADDR_WAKE_EN, rd); check(rd, WAKE_EN_RESET);
    rdr(ADDR_WDT_PERIOD, rd); check(rd, WDT_PERIOD_RESET);
    rdr(ADDR_STATUS, rd); check(rd, 8'h03);
    rdr(4'hc, rd); check(rd, 8'h00);
    $display("test reset done");
    // Entry freezes the pads and stops the oscillator
    held = io_drive_type'(16'($urandom));
    io_core <= held;
    cyc(3);
    sleep_now();
    check({asleep, osc_en, pd_n, to_n}, 4'h9);
    repeat (20) begin
      @(posedge ref_clk);
      io_core <= io_drive_type'(16'($urandom));
      #1 check(io_pins, held);
      check(osc_en, 1'b0);
    end
    // Late flag: entry completes, then an interrupt wake without branch
    wr(ADDR_WAKE_EN, 8'h40);
    raise <= 8'h40;
    @(posedge ref_clk);
    raise <= 8'h00;
    wait_resume();
    check({vb_seen, pd_n, to_n, asleep}, 4'h2);
    pulse_clear();
    $display("test entry and wake done");
    // Random enables and flags, each source and both global enable settings
    for (int i = 0; i < 12; i++) begin
      en = (i < 8) ? (8'h01 << i) : (8'($urandom) | 8'h01);
      fl = (i % 3 == 0) ? en : 8'($urandom);
      wr(ADDR_CTRL, {5'h00, i[0], 2'b00});
      wr(ADDR_WAKE_EN, en);
      raise <= fl;
      @(posedge ref_clk);
      raise <= 8'h00;
      cyc(1);
      sleep_now();
      check(asleep, (en & fl) == 8'h00);
      check(pd_n, (en & fl) != 8'h00);
      if (asleep === 1'b1 && en != 8'h00) begin
        raise <= pick(en);
        @(posedge ref_clk);
        raise <= 8'h00;
        wait_resume();
        check({vb_seen, asleep}, {i[0], 1'b0});
        if (i[0] == 1'b1) begin
          check(vector_addr, 13'h0004);
        end
      end
      pulse_clear();
    end
    wr(ADDR_WAKE_EN, 8'h00);
    $display("test random wake sources done");
    // Disabled sources leave the device asleep
    raise <= 8'hff;
    @(posedge ref_clk);
    raise <= 8'h00;
    sleep_now();
    cyc(30);
    #1 check(asleep, 1'b1);
    // Master clear while asleep resets and never driven by the device;
    // with the clock enable low even the pin synchroniser must stand still
    pin_low <= 1'b1;
    ce <= 1'b0;
    cyc(8);
    #1 check({core_reset, asleep}, 2'h1);
    ce <= 1'b1;
    cyc(6);
    #1 check({core_reset, asleep, mc_oe, pd_n}, 4'h8);
    pin_low <= 1'b0;
    cyc(6);
    pulse_clear();
    $display("test master clear done");
    // Watchdog wake: limit is {period, ff} cycles
    wr(ADDR_WDT_PERIOD, 8'h00);
    wr(ADDR_CTRL, 8'h05);
    sleep_now();
    wait_resume();
    check({to_n, vb_seen, asleep}, 3'h0);
    check(n > 200 && n < 300, 1'b1);
    rdr(ADDR_STATUS, rd);
    check(rd, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    pulse_clear();
    // Running time-out resets the core, pin stays an input
    wr(ADDR_CTRL, 8'h01);
    n = 0;
    while (n < 600 && core_reset !== 1'b1) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check({core_reset, mc_oe, mc_out, mc_n, to_n}, 5'h12);
    wr(ADDR_CTRL, 8'h00);
    pulse_clear();
    $display("test watchdog done");
    // Crystal mode waits for the start-up timer before resuming
    wr(ADDR_CTRL, 8'h02);
    wr(ADDR_WAKE_EN, 8'h01);
    // Flag rises while the instruction executes: full entry, then immediate wake
    @(posedge ref_clk);
    sleep_instr <= 1'b1;
    raise <= 8'h01;
    @(posedge ref_clk);
    sleep_instr <= 1'b0;
    raise <= 8'h00;
    #1 check({prefetch, asleep, pd_n, to_n}, 4'hd);
    wait_resume();
    check(n >= 1024 && n < 1100, 1'b1);
    rdr(ADDR_STATUS, rd);
    check(rd, 8'h11);
    rdr(ADDR_WAKE_FLAGS, rd);
    check(rd, 8'h01);
    pulse_clear();
    $display("test start-up timer done");
    conclude();
  end
endmodule : tb_sleep_wake_control

`default_nettype wire

// ===== dv/wake_source_model.sv
`timescale 1ns/1ps
`default_nettype none

module wake_source_model (
  input wire logic ref_clk, // System clock
  input wire logic nrst, // Reset, active low
  input wire logic [7:0] raise, // Flags to set at the next edge
  input wire logic clear_all, // Core clears every flag
  input wire logic pin_low, // External reset button pressed
  input wire logic pin_oe, // Device drive enable on the pin
  input wire logic pin_out, // Device drive value on the pin
  output logic [7:0] wake_flags, // Peripheral interrupt flags
  output logic master_clear_pin_n // Resolved pin level
);
  // ==========================================================================
  // Flags
  // Flags stay set until the core clears them, so a late flag still counts
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wake_flags <= 8'h00;
    end else if (clear_all) begin
      wake_flags <= 8'h00;
    end else begin
      wake_flags <= wake_flags | raise;
    end
  end

  // ==========================================================================
  // Pin
  // Pulled up; a device drive would win, which the bench would notice
  assign master_clear_pin_n = pin_oe ? pin_out : !pin_low;
endmodule : wake_source_model

`default_nettype wire

// ===== src/sleep_wake_control.sv
// How it works
// [R1] Power-down is entered only on the core's power-down instruction strobe.
// [R2] Entering power-down clears the watchdog count; watchdog keeps counting asleep.
// [R3] Entry drives powerdown_flag_n to zero and timeout_flag_n to one.
// [R4] Oscillator driver stays off for the whole power-down period.
// [R5] Every I/O keeps its level and drive enable captured just before entry.
// [R6] Watchdog reset never drives the master clear pin; the pin is input only.
// [R7] Wake on master clear, enabled watchdog time-out, or enabled interrupt.
// [R8] Master clear wake resets the core; watchdog and interrupt wakes resume.
// [R9] Watchdog wake clears timeout_flag_n so software sees the cause.
// [R10] powerdown_flag_n is one at power-up, zero whenever power-down really happens.
// [R11] Wake sources are the eight listed clockless peripherals and pins only.
// [R12] No other peripheral can raise a wake request while asleep.
// [R13] Next program address is prefetched while the power-down instruction executes.
// [R14] Only a source's own enable gates wake; global enable does not matter.
// [R15] Interrupt wake with global enable clear just continues after the instruction.
// [R16] With global enable set, run next instruction then branch to vector 0004h.
// [R17] Pending enabled flag before entry makes the instruction a no-operation.
// [R18] Flag set during or after entry: full entry, then immediate wake.
// [R19] Every wake-up clears the watchdog count.
// [R20] Crystal mode holds the watchdog cleared until the start-up timer ends.
// [R21] Wake request is OR of enable AND flag, combinational, needs no clock.
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module sleep_wake_control
  import sleep_wake_pkg::*;
(
  input wire logic ref_clk, // 40 MHz system clock
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic ce, // Clock enable, freezes all state when low
  input wire logic [3:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, one cycle after the strobe
  input wire logic sleep_instr, // Core executes the power-down instruction
  input wire logic watchdog_clear_instr, // Core executes the watchdog clear
  input wire logic [7:0] wake_flags, // Interrupt flags of the wake sources
  input wire io_drive_type io_core, // Port drive wanted by the core
  output io_drive_type io_pins, // Port drive applied to the pads
  input wire logic master_clear_pin_n, // External master clear pin level
  output logic master_clear_pin_out, // Pin output value, never driven
  output logic master_clear_pin_oe, // Pin output enable, never set
  output logic osc_driver_en, // Oscillator driver enable
  output logic asleep, // Device is in power-down
  output logic core_reset, // Reset request to the core
  output logic prefetch_next, // Core fetches the next address
  output logic core_resume, // Core continues after a wake-up
  output logic vector_branch, // Branch to the interrupt vector after next
  output logic [12:0] vector_addr, // Interrupt vector address
  output logic timeout_flag_n, // Time-out status flag, active low
  output logic powerdown_flag_n // Power-down status flag, active low
);

  // ==========================================================================
  // Registers
  ctrl_type ctrl;
  logic [7:0] wake_en;
  logic [7:0] wdt_period;
  power_state_type state;
  power_state_type next_state;
  logic [15:0] wdt_count;
  logic [10:0] ost_count;
  logic wake_by_irq;
  logic [2:0] master_clear_pin_n_sync;
  logic master_clear_pin_n_level_n;
  logic [7:0] wake_terms;
  logic wake_req;
  logic wdt_timeout;
  logic master_clear_pin_n_active;
  logic sleep_go;
  logic enter_sleep;
  logic wdt_wake;
  logic irq_wake;
  logic any_wake;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= CTRL_RESET;
      wake_en <= WAKE_EN_RESET;
      wdt_period <= WDT_PERIOD_RESET;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: begin
          ctrl.wdt_enable <= reg_wdata[CTRL_WDT_ENABLE_BIT];
          ctrl.crystal_mode <= reg_wdata[CTRL_CRYSTAL_BIT];
          ctrl.global_irq_enable <= reg_wdata[CTRL_GIE_BIT];
        end
        ADDR_WAKE_EN: wake_en <= reg_wdata;
        ADDR_WDT_PERIOD: wdt_period <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Unmapped addresses read as zero; data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      if (reg_rd) begin
        case (reg_addr)
          ADDR_CTRL: reg_rdata <= {5'h00, ctrl};
          ADDR_WAKE_EN: reg_rdata <= wake_en;
          ADDR_STATUS: begin
            reg_rdata <= 8'h00;
            reg_rdata[STAT_TIMEOUT_N_BIT] <= timeout_flag_n;
            reg_rdata[STAT_POWERDOWN_N_BIT] <= powerdown_flag_n;
            reg_rdata[STAT_ASLEEP_BIT] <= (state == ST_SLEEP);
            reg_rdata[STAT_STARTUP_BIT] <= (state == ST_STARTUP);
            reg_rdata[STAT_WAKE_IRQ_BIT] <= wake_by_irq;
          end
          ADDR_WDT_PERIOD: reg_rdata <= wdt_period;
          ADDR_WAKE_FLAGS: reg_rdata <= wake_flags;
          default: reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // Master clear pin: three stages, a change counts once stages two and three agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      master_clear_pin_n_sync <= 3'h7;
      master_clear_pin_n_level_n <= 1'b1;
    end else if (ce) begin
      master_clear_pin_n_sync <= {master_clear_pin_n_sync[1:0], master_clear_pin_n};
      if (master_clear_pin_n_sync[1] == master_clear_pin_n_sync[2]) begin
        master_clear_pin_n_level_n <= master_clear_pin_n_sync[2];
      end
    end
  end

  assign master_clear_pin_n_active = !master_clear_pin_n_level_n;

  // Pin is an input only; a watchdog reset goes to the core, never to the pin
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      master_clear_pin_out <= 1'b0;
      master_clear_pin_oe <= 1'b0; // R6
    end else if (ce) begin
      master_clear_pin_out <= 1'b0;
      master_clear_pin_oe <= 1'b0; // R6
    end
  end

  // ==========================================================================
  // Wake request, purely combinational so it works with the clocks stopped
  for (genvar i = 0; i < WAKE_SOURCES; i++) begin : g_wake
    assign wake_terms[i] = wake_en[i] & wake_flags[i]; // R11 R12 R14
  end

  assign wake_req = |wake_terms; // R21

  assign wdt_timeout = ctrl.wdt_enable && (wdt_count == {wdt_period, WDT_PERIOD_LOW});
  assign sleep_go = sleep_instr && (state == ST_RUN) && !master_clear_pin_n_active; // R1
  assign enter_sleep = sleep_go && !wake_req; // R17
  assign wdt_wake = (state == ST_SLEEP) && !master_clear_pin_n_active && wdt_timeout; // R7
  assign irq_wake = (state == ST_SLEEP) && !master_clear_pin_n_active && !wdt_timeout && wake_req; // R7 R18
  assign any_wake = wdt_wake || irq_wake;

  // ==========================================================================
  // Power state machine
  always_comb begin
    next_state = state;
    if (master_clear_pin_n_active) begin
      next_state = ST_RUN; // R8
    end else begin
      case (state)
        ST_RUN: if (enter_sleep) next_state = ST_SLEEP;
        ST_SLEEP: if (any_wake) next_state = ctrl.crystal_mode ? ST_STARTUP : ST_RESUME;
        ST_STARTUP: if (ost_count == 11'h000) next_state = ST_RESUME;
        ST_RESUME: next_state = ST_RUN;
        default: next_state = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_RUN;
      asleep <= 1'b0;
      osc_driver_en <= 1'b1;
    end else if (ce) begin
      state <= next_state;
      asleep <= (next_state == ST_SLEEP);
      osc_driver_en <= (next_state != ST_SLEEP); // R4
    end
  end

  // Start-up timer lets a crystal settle before the core runs again
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ost_count <= 11'h000;
    end else if (ce) begin
      if (state == ST_SLEEP) begin
        ost_count <= OST_CYCLES - 11'h001;
      end else if (state == ST_STARTUP && ost_count != 11'h000) begin
        ost_count <= ost_count - 11'h001;
      end
    end
  end

  // ==========================================================================
  // Watchdog counter
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wdt_count <= 16'h0000;
    end else if (ce) begin
      if (!ctrl.wdt_enable) begin
        wdt_count <= 16'h0000;
      end else if (enter_sleep) begin
        wdt_count <= 16'h0000; // R2 R18
      end else if (any_wake || master_clear_pin_n_active) begin
        wdt_count <= 16'h0000; // R19
      end else if (state == ST_STARTUP) begin
        wdt_count <= 16'h0000; // R20
      end else if (watchdog_clear_instr && state == ST_RUN) begin
        wdt_count <= 16'h0000;
      end else if (wdt_timeout) begin
        wdt_count <= 16'h0000;
      end else begin
        wdt_count <= wdt_count + 16'h0001; // R2
      end
    end
  end

  // ==========================================================================
  // Status flags; a no-operation entry leaves both untouched
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1; // R10
    end else if (ce) begin
      if (enter_sleep) begin
        timeout_flag_n <= 1'b1; // R3
        powerdown_flag_n <= 1'b0; // R3 R10
      end else if (wdt_wake) begin
        timeout_flag_n <= 1'b0; // R9
      end else if (state == ST_RUN && wdt_timeout && !master_clear_pin_n_active) begin
        timeout_flag_n <= 1'b0;
        powerdown_flag_n <= 1'b1;
      end else if (state == ST_RUN && watchdog_clear_instr) begin
        timeout_flag_n <= 1'b1;
        powerdown_flag_n <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Core handshakes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      core_reset <= 1'b0;
      prefetch_next <= 1'b0;
    end else if (ce) begin
      // Awake watchdog time-out resets the core only; the pin is left alone
      core_reset <= master_clear_pin_n_active || (state == ST_RUN && wdt_timeout); // R8 R6
      prefetch_next <= sleep_go; // R13
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wake_by_irq <= 1'b0;
    end else if (ce) begin
      if (irq_wake) begin
        wake_by_irq <= 1'b1;
      end else if (wdt_wake || enter_sleep) begin
        wake_by_irq <= 1'b0;
      end
    end
  end

  // Global enable only decides whether the vector follows, never whether we wake
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      core_resume <= 1'b0;
      vector_branch <= 1'b0;
      vector_addr <= 13'h0000;
    end else if (ce) begin
      core_resume <= (state == ST_RESUME) && !master_clear_pin_n_active; // R8 R15
      vector_branch <= (state == ST_RESUME) && !master_clear_pin_n_active && wake_by_irq
                       && ctrl.global_irq_enable; // R16
      if (state == ST_RESUME && wake_by_irq && ctrl.global_irq_enable) begin
        vector_addr <= IRQ_VECTOR; // R16
      end
    end
  end

  // ==========================================================================
  // I/O hold: drive state frozen at entry, so the pads do not glitch asleep
  for (genvar b = 0; b < 8; b++) begin : g_io_hold
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        io_pins.level[b] <= 1'b0;
        io_pins.enable[b] <= 1'b0;
      end else if (ce && next_state != ST_SLEEP) begin
        io_pins.level[b] <= io_core.level[b];
        io_pins.enable[b] <= io_core.enable[b];
      end else if (ce && state != ST_SLEEP) begin
        io_pins.level[b] <= io_core.level[b]; // R5
        io_pins.enable[b] <= io_core.enable[b]; // R5
      end
    end
  end

  // ==========================================================================
  // Checks
  sequence seq_enter;
    ce && enter_sleep && !master_clear_pin_n_active;
  endsequence

  sequence seq_entered;
    !powerdown_flag_n && timeout_flag_n && state == ST_SLEEP;
  endsequence

  chk_entry_flags: assert property (@(posedge ref_clk) disable iff (!nrst) // R3
    seq_enter |=> seq_entered)
    else $error("power-down entry did not set the status flags");

  chk_nop_entry: assert property (@(posedge ref_clk) disable iff (!nrst) // R17
    ce && sleep_go && wake_req |=> $stable(powerdown_flag_n) && $stable(timeout_flag_n)
      && state == ST_RUN && (wdt_count == $past(wdt_count) + 16'h0001 || wdt_count == 16'h0000))
    else $error("pending wake did not turn the instruction into a no-operation");

  chk_pd_cause: assert property (@(posedge ref_clk) disable iff (!nrst) // R1
    $fell(powerdown_flag_n) |-> $past(sleep_instr) && $past(ce))
    else $error("power-down flag cleared without the instruction");

  chk_osc_off: assert property (@(posedge ref_clk) disable iff (!nrst) // R4
    osc_driver_en == (state != ST_SLEEP))
    else $error("oscillator driver on while asleep");

  chk_io_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // R5
    state == ST_SLEEP && $past(state) == ST_SLEEP |-> $stable(io_pins))
    else $error("pad drive changed during power-down");

  chk_pin_input: assert property (@(posedge ref_clk) disable iff (!nrst) // R6
    !master_clear_pin_oe && !master_clear_pin_out)
    else $error("master clear pin driven");

  chk_wdt_wake: assert property (@(posedge ref_clk) disable iff (!nrst) // R9
    ce && wdt_wake |=> !timeout_flag_n && state != ST_SLEEP)
    else $error("watchdog wake did not clear the time-out flag");

  chk_wake_clear: assert property (@(posedge ref_clk) disable iff (!nrst) // R19
    ce && any_wake |=> wdt_count == 16'h0000)
    else $error("watchdog not cleared at wake-up");

  chk_startup_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // R20
    state == ST_STARTUP |-> wdt_count == 16'h0000)
    else $error("watchdog counted during oscillator start-up");

  chk_fast_wake: assert property (@(posedge ref_clk) disable iff (!nrst) // R18
    seq_enter ##1 (ce && wake_req && !master_clear_pin_n_active && !wdt_timeout)
      |=> state != ST_SLEEP && wdt_count == 16'h0000)
    else $error("late wake flag did not wake immediately");

  chk_prefetch: assert property (@(posedge ref_clk) disable iff (!nrst) // R13
    ce && sleep_go |=> prefetch_next)
    else $error("no prefetch during the power-down instruction");

  chk_vector: assert property (@(posedge ref_clk) disable iff (!nrst) // R15
    ce && state == ST_RESUME && !master_clear_pin_n_active |=> core_resume
      && vector_branch == ($past(wake_by_irq) && $past(ctrl.global_irq_enable)))
    else $error("resume or vector branch wrong after wake-up");

  chk_vector_addr: assert property (@(posedge ref_clk) disable iff (!nrst) // R16
    vector_branch |-> vector_addr == IRQ_VECTOR)
    else $error("vector branch to the wrong address");

  chk_master_clear_pin_n_reset: assert property (@(posedge ref_clk) disable iff (!nrst) // R8
    ce && master_clear_pin_n_active |=> core_reset && state == ST_RUN)
    else $error("master clear did not reset the core");

endmodule : sleep_wake_control

`default_nettype wire

// ===== src/sleep_wake_pkg.sv
package sleep_wake_pkg;

  // ==========================================================================
  // Register map (4-bit word address, 8-bit data)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_WAKE_EN = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_WDT_PERIOD = 4'h3;
  localparam logic [3:0] ADDR_WAKE_FLAGS = 4'h4;

  // ==========================================================================
  // Field positions
  localparam int CTRL_WDT_ENABLE_BIT = 0;
  localparam int CTRL_CRYSTAL_BIT = 1;
  localparam int CTRL_GIE_BIT = 2;
  localparam int STAT_TIMEOUT_N_BIT = 0;
  localparam int STAT_POWERDOWN_N_BIT = 1;
  localparam int STAT_ASLEEP_BIT = 2;
  localparam int STAT_STARTUP_BIT = 3;
  localparam int STAT_WAKE_IRQ_BIT = 4;

  // Wake-capable sources, one bit each
  localparam int WAKE_TIMER_ONE = 0;
  localparam int WAKE_ENHANCED_CAPTURE = 1;
  localparam int WAKE_ADC_ON_RC = 2;
  localparam int WAKE_EEPROM_DONE = 3;
  localparam int WAKE_COMPARATOR = 4;
  localparam int WAKE_PORT_CHANGE = 5;
  localparam int WAKE_EDGE_PIN = 6;
  localparam int WAKE_SERIAL_I2C = 7;
  localparam int WAKE_SOURCES = 8;

  // ==========================================================================
  // Reset values and counts
  localparam logic [7:0] WAKE_EN_RESET = 8'h00;
  localparam logic [7:0] WDT_PERIOD_RESET = 8'hff;
  localparam logic [7:0] WDT_PERIOD_LOW = 8'hff;
  localparam logic [10:0] OST_CYCLES = 11'h400;
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic global_irq_enable;
    logic crystal_mode;
    logic wdt_enable;
  } ctrl_type;

  localparam ctrl_type CTRL_RESET = '{global_irq_enable: 1'b0, crystal_mode: 1'b0,
                                      wdt_enable: 1'b0};

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] enable;
  } io_drive_type;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_STARTUP = 2'b11,
    ST_RESUME = 2'b10
  } power_state_type;

endpackage : sleep_wake_pkg
